// ### rtl/fie_map.svh
// Functional notes
// - fault reaches collector within ten oscillator cycles
// - fast switching shows fault within 64 us
// - slow switching delay up to 8 ms half-period
// - bi-stable shows fault within 64 us
// - safe state: pins, high impedance or reset
// - exactly two error-out pins, indexed 0 and 1
// - protocol: dual rail, time switching, bi-stable, test
// - after power-on pins high impedance, never operational
// - error flag readable; write 1 fault, 0 operational
// - operational state only on software request
// - operational: at least one pin high, except in test protocol
// - bi-stable pins complementary, polarity chosen by software
// - fault source kept across functional reset
// - failure indication held minimum time after clear
// - software may request whole device reset
`ifndef FIE_MAP_SVH
`define FIE_MAP_SVH

// ============================================================
// sizes
`define FIE_NUM_FAULTS 8
`define FIE_NUM_PINS 2
`define FIE_HOLD_W 16

// ============================================================
// timing
`define FIE_CLK_PERIOD_NS 10
`define FIE_RC_PERIOD_PS 62500
`define FIE_HANDOFF_RC_CYC 10
`define FIE_HANDOFF_CYC ((`FIE_HANDOFF_RC_CYC * `FIE_RC_PERIOD_PS) / (1000 * `FIE_CLK_PERIOD_NS))
`define FIE_FAST_IND_NS 64000
`define FIE_FAST_IND_CYC (`FIE_FAST_IND_NS / `FIE_CLK_PERIOD_NS)
`define FIE_FAST_HALF_NS 32000
`define FIE_FAST_HALF_CYC (`FIE_FAST_HALF_NS / `FIE_CLK_PERIOD_NS)
`define FIE_SLOW_HALF_NS 8000000
`define FIE_SLOW_HALF_CYC (`FIE_SLOW_HALF_NS / `FIE_CLK_PERIOD_NS)

// ============================================================
// reset values
`define FIE_PINS_RST 2'h0
`define FIE_OE_RST 2'h0

`endif

// ### rtl/fie_pkg.sv
`include "fie_map.svh"

package fie_pkg;

    typedef enum logic [1:0] {
        PROTO_DUAL_RAIL = 2'h0,
        PROTO_TIME_SW = 2'h1,
        PROTO_BISTABLE = 2'h2,
        PROTO_TEST = 2'h3
    } fie_proto_e;

    typedef enum logic [1:0] {
        REACT_PINS = 2'h0,
        REACT_HIZ = 2'h1,
        REACT_RESET = 2'h2,
        REACT_SPARE = 2'h3
    } fie_react_e;

    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_FAULT = 4'h2,
        ST_HOLD = 4'h4,
        ST_OPER = 4'h8
    } fie_state_e;

    typedef struct packed {
        fie_proto_e protocol;
        logic fast;
        logic polarity;
        fie_react_e reaction;
        logic [`FIE_NUM_PINS-1:0] test_pins;
        logic [`FIE_HOLD_W-1:0] hold_cyc;
    } fie_cfg_s;

endpackage : fie_pkg

// ### rtl/fie_toggle.sv
`timescale 1ns/1ps

module fie_toggle #(
    parameter int HALF = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // toggle outputs
    output logic o_phase,
    output logic o_tick
);

    localparam int W = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [W-1:0] LAST = W'(HALF - 1);

    logic [W-1:0] cnt;

    // ============================================================
    // half-period counter
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_phase <= 1'b0;
            o_tick <= 1'b0;
        end else if (cnt == LAST) begin
            cnt <= '0;
            o_phase <= ~o_phase;
            o_tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            o_tick <= 1'b0;
        end
    end

endmodule : fie_toggle

// ### rtl/fie_top.sv
`timescale 1ns/1ps
`include "fie_map.svh"

module fie_top #(
    parameter int SLOW_HALF_CYC = `FIE_SLOW_HALF_CYC
) (
    // clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_func_rst_n,
    // fault inputs from safety mechanisms
    input wire logic [`FIE_NUM_FAULTS-1:0] i_fault_in,
    // software control
    input wire fie_pkg::fie_cfg_s i_cfg,
    input wire logic i_sw_err_wr,
    input wire logic i_sw_err_wdata,
    input wire logic [`FIE_NUM_FAULTS-1:0] i_sw_fault_clr,
    input wire logic i_sw_reset_req,
    // status
    output logic o_err_status,
    output logic [`FIE_NUM_FAULTS-1:0] o_fault_src,
    // error-out pins
    output logic [`FIE_NUM_PINS-1:0] o_error_out_pins,
    output logic [`FIE_NUM_PINS-1:0] o_error_out_oe,
    // safe-state reactions
    output logic o_outputs_hiz,
    output logic o_reset_req
);

    localparam int HANDOFF_CYC = `FIE_HANDOFF_CYC;
    localparam int FAST_IND_CYC = `FIE_FAST_IND_CYC;

    fie_pkg::fie_state_e state;
    fie_pkg::fie_state_e next_state;
    logic rst_all_n;
    logic [`FIE_HOLD_W-1:0] hold_cnt;
    logic show_fail;
    logic next_show_fail;
    logic fast_phase;
    logic fast_tick;
    logic slow_phase;
    logic slow_tick;
    logic phase;
    logic tick;
    logic toggling;
    logic any_fault;
    logic sw_oper;
    logic [`FIE_NUM_PINS-1:0] next_pins;
    logic [`FIE_NUM_PINS-1:0] next_oe;

    assign rst_all_n = i_rst_n & i_func_rst_n;
    assign any_fault = (|o_fault_src) | (|i_fault_in);
    assign sw_oper = i_sw_err_wr & ~i_sw_err_wdata;

    // ============================================================
    // toggle sources
    fie_toggle #(.HALF(`FIE_FAST_HALF_CYC)) u_fast (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_all_n),
        .o_phase(fast_phase),
        .o_tick(fast_tick)
    );

    fie_toggle #(.HALF(SLOW_HALF_CYC)) u_slow (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_all_n),
        .o_phase(slow_phase),
        .o_tick(slow_tick)
    );

    assign phase = i_cfg.fast ? fast_phase : slow_phase;
    assign tick = i_cfg.fast ? fast_tick : slow_tick;
    assign toggling = (i_cfg.protocol == fie_pkg::PROTO_DUAL_RAIL) ||
                      (i_cfg.protocol == fie_pkg::PROTO_TIME_SW);

    // ============================================================
    // fault source latch, kept over functional reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_fault_src <= '0;
        end else begin
            o_fault_src <= (o_fault_src & ~i_sw_fault_clr) | i_fault_in;
        end
    end

    // ============================================================
    // collector state
    always_comb begin
        next_state = state;
        unique case (state)
            fie_pkg::ST_POR: begin
                if (any_fault || (i_sw_err_wr && i_sw_err_wdata)) begin
                    next_state = fie_pkg::ST_FAULT;
                end else if (sw_oper) begin
                    next_state = fie_pkg::ST_OPER;
                end
            end
            fie_pkg::ST_FAULT: begin
                if (sw_oper && !any_fault) begin
                    next_state = fie_pkg::ST_HOLD;
                end
            end
            fie_pkg::ST_HOLD: begin
                if (any_fault || (i_sw_err_wr && i_sw_err_wdata)) begin
                    next_state = fie_pkg::ST_FAULT;
                end else if (hold_cnt >= i_cfg.hold_cyc) begin
                    next_state = fie_pkg::ST_OPER;
                end
            end
            fie_pkg::ST_OPER: begin
                if (any_fault || (i_sw_err_wr && i_sw_err_wdata)) begin
                    next_state = fie_pkg::ST_FAULT;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            state <= fie_pkg::ST_POR;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            hold_cnt <= '0;
        end else if (state == fie_pkg::ST_HOLD) begin
            if (hold_cnt != '1) begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end else begin
            hold_cnt <= '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            o_err_status <= 1'b1;
        end else begin
            o_err_status <= (next_state != fie_pkg::ST_OPER);
        end
    end

    // ============================================================
    // indication timing: slow toggling waits for its half-period edge
    always_comb begin
        next_show_fail = show_fail;
        if (!toggling || i_cfg.fast || tick || state == fie_pkg::ST_POR) begin
            next_show_fail = (state != fie_pkg::ST_OPER);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            show_fail <= 1'b1;
        end else begin
            show_fail <= next_show_fail;
        end
    end

    // ============================================================
    // error-out pin protocols
    always_comb begin
        next_oe = {`FIE_NUM_PINS{1'b1}};
        next_pins = 2'h0;
        unique case (i_cfg.protocol)
            fie_pkg::PROTO_DUAL_RAIL: begin
                next_pins = show_fail ? 2'h0 : {~phase, phase};
            end
            fie_pkg::PROTO_TIME_SW: begin
                next_pins = show_fail ? 2'h0 : {1'b1, phase};
            end
            fie_pkg::PROTO_BISTABLE: begin
                next_pins = {~i_cfg.polarity, i_cfg.polarity} ^ {2{show_fail}};
            end
            fie_pkg::PROTO_TEST: begin
                next_pins = i_cfg.test_pins;
            end
        endcase
        if (state == fie_pkg::ST_POR) begin
            next_oe = `FIE_OE_RST;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            o_error_out_pins <= `FIE_PINS_RST;
            o_error_out_oe <= `FIE_OE_RST;
        end else begin
            o_error_out_pins <= next_pins;
            o_error_out_oe <= next_oe;
        end
    end

    // ============================================================
    // safe-state reactions
    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n) begin
            o_outputs_hiz <= 1'b0;
            o_reset_req <= 1'b0;
        end else begin
            o_outputs_hiz <= (next_state == fie_pkg::ST_FAULT) &&
                             (i_cfg.reaction == fie_pkg::REACT_HIZ);
            o_reset_req <= i_sw_reset_req || ((next_state == fie_pkg::ST_FAULT) &&
                           (i_cfg.reaction == fie_pkg::REACT_RESET));
        end
    end

    // ============================================================
    // assertions
    logic [31:0] wait_cnt;
    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n || show_fail || state == fie_pkg::ST_OPER) begin
            wait_cnt <= '0;
        end else begin
            wait_cnt <= wait_cnt + 32'h1;
        end
    end

    a_fault_handoff: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        |i_fault_in |-> ##[1:HANDOFF_CYC] (o_err_status && (o_fault_src != '0)))
        else $error("fault not handed to collector in time");

    // cycles since a fast-mode fault arrived with the failure pattern still off
    logic [12:0] fast_wait;
    always_ff @(posedge i_core_clk) begin
        if (!rst_all_n || show_fail || !i_cfg.fast) begin
            fast_wait <= '0;
        end else if ((|i_fault_in) || (fast_wait != '0)) begin
            fast_wait <= fast_wait + 13'h1;
        end
    end

    a_fast_indicate: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        fast_wait <= 13'(FAST_IND_CYC))
        else $error("fast switching indication late");

    a_slow_bound: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        wait_cnt <= 32'(SLOW_HALF_CYC) + 32'h2)
        else $error("slow switching indication beyond half period");

    a_bistable_fault: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (state == fie_pkg::ST_OPER && |i_fault_in &&
         i_cfg.protocol == fie_pkg::PROTO_BISTABLE) |=> ##2
        (o_error_out_pins == ~{~$past(i_cfg.polarity, 3), $past(i_cfg.polarity, 3)}))
        else $error("bistable indication not inverted");

    a_hiz_react: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (next_state == fie_pkg::ST_FAULT && i_cfg.reaction == fie_pkg::REACT_HIZ)
        |=> o_outputs_hiz)
        else $error("high impedance reaction missing");

    a_por_tristate: assert property (@(posedge i_core_clk)
        !i_rst_n |=> (o_error_out_oe == 2'h0 && o_err_status))
        else $error("pins driven after power-on reset");

    a_sw_flag: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (i_sw_err_wr && i_sw_err_wdata) |=> o_err_status)
        else $error("software fault write not shown");

    a_no_auto_oper: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (state == fie_pkg::ST_POR && next_state == fie_pkg::ST_OPER) |-> sw_oper)
        else $error("operational without software request");

    a_oper_high: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (state == fie_pkg::ST_OPER && !show_fail && i_cfg.protocol != fie_pkg::PROTO_TEST)
        |=> (|o_error_out_pins))
        else $error("no pin high while operational");

    a_bistable_comp: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (i_cfg.protocol == fie_pkg::PROTO_BISTABLE) |=>
        (o_error_out_pins[0] != o_error_out_pins[1]))
        else $error("bistable pins not complementary");

    a_src_keep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_func_rst_n && i_fault_in == '0 && i_sw_fault_clr == '0) |=> $stable(o_fault_src))
        else $error("fault source lost on functional reset");

    a_hold_min: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        (state == fie_pkg::ST_HOLD && hold_cnt < i_cfg.hold_cyc) |=> state != fie_pkg::ST_OPER)
        else $error("failure indication left too early");

    a_sw_reset: assert property (@(posedge i_core_clk) disable iff (!rst_all_n)
        i_sw_reset_req |=> o_reset_req)
        else $error("software reset request dropped");

endmodule : fie_top

// ### tb/fie_supervisor.sv
`timescale 1ns/1ps

module fie_supervisor (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // error-out pins seen at the board
    input wire logic [1:0] i_pins,
    input wire logic [1:0] i_oe,
    // supervisor verdict
    output logic o_safe
);
    // ============================================================
    // safe on reset, released pins or all-low indication
    always_ff @(posedge i_core_clk) begin
        o_safe <= !i_rst_n || (i_oe != 2'h3) || (i_pins == 2'h0);
    end
endmodule : fie_supervisor

// ### tb/test_fault_indication_error_out.sv
`timescale 1ns/1ps
`include "fie_map.svh"

module test_fault_indication_error_out;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_func_rst_n = 1'b1;
    logic [7:0] i_fault_in = 8'h00;
    fie_pkg::fie_cfg_s i_cfg = '0;
    logic i_sw_err_wr = 1'b0;
    logic i_sw_err_wdata = 1'b0;
    logic [7:0] i_sw_fault_clr = 8'h00;
    logic i_sw_reset_req = 1'b0;
    logic o_err_status, o_outputs_hiz, o_reset_req, sup_safe;
    logic [7:0] o_fault_src;
    logic [1:0] o_error_out_pins, o_error_out_oe, p0;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;

    always #5 i_core_clk = ~i_core_clk;

    fie_top #(.SLOW_HALF_CYC(20)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_func_rst_n(i_func_rst_n), .i_fault_in(i_fault_in), .i_cfg(i_cfg),
        .i_sw_err_wr(i_sw_err_wr), .i_sw_err_wdata(i_sw_err_wdata),
        .i_sw_fault_clr(i_sw_fault_clr), .i_sw_reset_req(i_sw_reset_req),
        .o_err_status(o_err_status), .o_fault_src(o_fault_src),
        .o_error_out_pins(o_error_out_pins), .o_error_out_oe(o_error_out_oe),
        .o_outputs_hiz(o_outputs_hiz), .o_reset_req(o_reset_req));

    fie_supervisor sup (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_pins(o_error_out_pins), .i_oe(o_error_out_oe), .o_safe(sup_safe));

    // ============================================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask : cyc

    task automatic fault(input logic [7:0] m);
        @(posedge i_core_clk);
        i_fault_in <= m;
        @(posedge i_core_clk);
        i_fault_in <= 8'h00;
        #1;
    endtask : fault

    task automatic clr(input logic [7:0] m);
        @(posedge i_core_clk);
        i_sw_fault_clr <= m;
        @(posedge i_core_clk);
        i_sw_fault_clr <= 8'h00;
    endtask : clr

    task automatic sw_wr(input logic v);
        @(posedge i_core_clk);
        i_sw_err_wr <= 1'b1;
        i_sw_err_wdata <= v;
        @(posedge i_core_clk);
        i_sw_err_wr <= 1'b0;
        #1;
    endtask : sw_wr

    // counts cycles until the flag drops, bounded
    task automatic to_oper(input int lim, output int k);
        k = 0;
        while (o_err_status !== 1'b0 && k < lim) begin
            cyc(1);
            k++;
        end
        chk("err_status_oper", 8'h0, {7'h0, o_err_status});
    endtask : to_oper

    task automatic wait_pins(input logic [1:0] e, input int lim);
        n = 0;
        while (o_error_out_pins !== e && n < lim) begin
            cyc(1);
            n++;
        end
        chk("pins", {6'h0, e}, {6'h0, o_error_out_pins});
    endtask : wait_pins

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles > 60000) begin
            failures++;
            stop_test();
        end
    end

    // ============================================================
    // tests
    initial begin
        i_cfg.hold_cyc <= 16'h000a;
        i_cfg.fast <= 1'b1;
        cyc(20);
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        cyc(1);
        chk("oe_por", 8'h0, {6'h0, o_error_out_oe});
        chk("err_por", 8'h1, {7'h0, o_err_status});
        chk("safe_por", 8'h1, {7'h0, sup_safe});
        cyc(30);
        chk("err_no_auto", 8'h1, {7'h0, o_err_status});
        sw_wr(1'b0);
        to_oper(3, n);
        cyc(2);
        p0 = o_error_out_pins;
        chk("dual_rail", 8'h1, {7'h0, ^p0});
        for (int i = 0; i < 8; i++) begin
            cyc(400);
            chk("pins_oe", 8'h3, {6'h0, o_error_out_oe});
            chk("one_high", 8'h1, {7'h0, |o_error_out_pins});
            chk("safe_oper", 8'h0, {7'h0, sup_safe});
        end
        cyc(300);
        chk("toggle", {6'h0, ~p0}, {6'h0, o_error_out_pins});
        $display("test dual rail done");

        fault(8'h21);
        chk("src", 8'h21, o_fault_src);
        chk("err_set", 8'h1, {7'h0, o_err_status});
        wait_pins(2'h0, 6400);
        cyc(1);
        chk("safe_fault", 8'h1, {7'h0, sup_safe});
        sw_wr(1'b0);
        cyc(15);
        chk("refuse", 8'h1, {7'h0, o_err_status});
        @(posedge i_core_clk);
        i_func_rst_n <= 1'b0;
        cyc(2);
        @(posedge i_core_clk);
        i_func_rst_n <= 1'b1;
        cyc(1);
        chk("src_kept", 8'h21, o_fault_src);
        chk("err_kept", 8'h1, {7'h0, o_err_status});
        clr(8'h01);
        cyc(1);
        chk("src_clr", 8'h20, o_fault_src);
        clr(8'h20);
        sw_wr(1'b0);
        to_oper(20, n);
        chk("hold_min", 8'h1, {7'h0, n >= 10});
        sw_wr(1'b1);
        chk("sw_fault", 8'h1, {7'h0, o_err_status});
        $display("test collect done");

        @(posedge i_core_clk);
        i_cfg.protocol <= fie_pkg::PROTO_BISTABLE;
        for (int p = 0; p < 2; p++) begin
            i_cfg.polarity <= p[0];
            sw_wr(1'b0);
            to_oper(20, n);
            wait_pins({~p[0], p[0]}, 4);
            fault(8'h02);
            wait_pins({p[0], ~p[0]}, 6400);
            clr(8'h02);
        end
        $display("test bistable done");

        @(posedge i_core_clk);
        i_cfg.protocol <= fie_pkg::PROTO_TEST;
        i_cfg.test_pins <= 2'h1;
        #1;
        wait_pins(2'h1, 4);
        @(posedge i_core_clk);
        i_cfg.protocol <= fie_pkg::PROTO_TIME_SW;
        i_cfg.fast <= 1'b0;
        sw_wr(1'b0);
        to_oper(20, n);
        n = 0;
        while (o_error_out_pins[1] !== 1'b1 && n < 24) begin
            cyc(1);
            n++;
        end
        chk("ts_pin1", 8'h1, {7'h0, o_error_out_pins[1]});
        p0 = o_error_out_pins;
        cyc(20);
        chk("ts_toggle", {6'h0, p0 ^ 2'h1}, {6'h0, o_error_out_pins});
        fault(8'h04);
        wait_pins(2'h0, 24);
        clr(8'h04);
        $display("test time switching done");

        @(posedge i_core_clk);
        i_cfg.reaction <= fie_pkg::REACT_HIZ;
        sw_wr(1'b0);
        to_oper(20, n);
        chk("hiz_idle", 8'h0, {7'h0, o_outputs_hiz});
        fault(8'h08);
        cyc(1);
        chk("hiz", 8'h1, {7'h0, o_outputs_hiz});
        @(posedge i_core_clk);
        i_cfg.reaction <= fie_pkg::REACT_RESET;
        fault(8'h10);
        cyc(1);
        chk("rst_react", 8'h1, {7'h0, o_reset_req});
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        cyc(2);
        chk("src_por", 8'h0, o_fault_src);
        chk("oe_rst", 8'h0, {6'h0, o_error_out_oe});
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        i_cfg.reaction <= fie_pkg::REACT_PINS;
        cyc(2);
        chk("err_rst", 8'h1, {7'h0, o_err_status});
        chk("rst_idle", 8'h0, {7'h0, o_reset_req});
        @(posedge i_core_clk);
        i_sw_reset_req <= 1'b1;
        @(posedge i_core_clk);
        i_sw_reset_req <= 1'b0;
        #1;
        chk("sw_rst", 8'h1, {7'h0, o_reset_req});
        cyc(2);
        chk("sw_rst_end", 8'h0, {7'h0, o_reset_req});
        $display("test reactions done");
        stop_test();
    end
endmodule : test_fault_indication_error_out
